// File: rtl/dat_top.sv
`timescale 1ns/1ps
`include "dat_defs.svh"
// Overview of operation
// - A request page must hold page code 40h, a zero byte 1 and page length 000Ah in bytes 2 and 3.
// - Once the whole parameter list is read, Good status is returned if the page has no error.
// - Conversion is deferred to the following receive command and its result is sent in that data.
// - Supplied format codes are 000b short block, 011b long block, 100b bytes-from-index, 101b physical.
// - A short or long block source accepts only bytes-from-index or physical as target.
// - A bytes-from-index or physical source accepts only long block as target.
// - A bad format code or equal formats ends with Check Condition, Illegal Request, bad parameter field.
// - A physical address is cylinder in bytes 6-8, head in byte 9, sector or byte offset in bytes 10-13.
// - The target format comes from byte 5 and the address from bytes 6 to 13.
module dat_top (
    // Clock and reset
    input  wire logic       CLOCK_I,
    input  wire logic       RSTN_I,
    // Parameter list bytes of the send command
    input  wire logic       PARAM_VALID_I,
    input  wire logic [7:0] PARAM_DATA_I,
    input  wire logic       PARAM_LAST_I,
    // Send command status
    output logic            STATUS_VALID_O,
    output logic            STATUS_GOOD_O,
    output logic [3:0]      SENSE_KEY_O,
    output logic [7:0]      ASC_O,
    // Receive command and returned page
    input  wire logic       RECV_REQ_I,
    output logic            RESULT_VALID_O,
    output logic [7:0]      RESULT_DATA_O,
    output logic            RESULT_LAST_O
);

    function automatic logic fmt_known(input logic [2:0] f);
        return f == `DAT_FMT_SHORT || f == `DAT_FMT_LONG || f == `DAT_FMT_BFI || f == `DAT_FMT_PHYS;
    endfunction : fmt_known

    function automatic logic fmt_block(input logic [2:0] f);
        return f == `DAT_FMT_SHORT || f == `DAT_FMT_LONG;
    endfunction : fmt_block

    function automatic logic pair_ok(input logic [2:0] s, input logic [2:0] d);
        if (!fmt_known(s) || !fmt_known(d) || s == d)
            return 1'b0;
        if (fmt_block(s))
            return d == `DAT_FMT_BFI || d == `DAT_FMT_PHYS;
        return d == `DAT_FMT_LONG;
    endfunction : pair_ok

    function automatic logic [63:0] translate(input dat_pkg::dat_req_s r);
        logic [63:0] lba;
        logic [31:0] sec;
        lba = 64'h0;
        sec = 32'h0;
        if (fmt_block(r.src)) begin
            lba = (r.src == `DAT_FMT_SHORT) ? {32'h0, r.addr[63:32]} : r.addr;
            sec = {24'h0, lba[7:0]};
            if (r.dst == `DAT_FMT_BFI)
                sec = sec << `DAT_BPS_LOG2;
            return {lba[35:12], 4'h0, lba[11:8], sec};
        end
        sec = (r.src == `DAT_FMT_BFI) ? (r.addr[31:0] >> `DAT_BPS_LOG2) : r.addr[31:0];
        return {28'h0, r.addr[63:40], r.addr[35:32], sec[7:0]};
    endfunction : translate

    dat_pkg::dat_state_e state, next_state;
    logic [3:0]          cnt, next_cnt;
    logic                overrun, next_overrun;
    logic [7:0]          pbuf [0:13];
    logic [7:0]          next_pbuf [0:13];
    dat_pkg::dat_req_s   req, next_req;
    logic                stored, next_stored;
    logic [63:0]         res_addr, next_res_addr;
    dat_pkg::dat_status_s status, next_status;
    logic                st_valid, next_st_valid;
    logic                res_valid, next_res_valid;
    logic [7:0]          res_data, next_res_data;
    logic                res_last, next_res_last;
    logic [7:0]          last_byte;
    logic                page_ok;
    dat_pkg::dat_req_s   cand;

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_overrun   = overrun;
        next_req       = req;
        next_stored    = stored;
        next_res_addr  = res_addr;
        next_status    = status;
        next_st_valid  = 1'b0;
        next_res_valid = 1'b0;
        next_res_data  = res_data;
        next_res_last  = 1'b0;
        for (int i = 0; i < 14; i++)
            next_pbuf[i] = pbuf[i];
        last_byte = PARAM_DATA_I;
        cand.src  = (cnt == `DAT_PAGE_BYTES) ? pbuf[`DAT_BYTE_SRC][2:0] : 3'h0;
        cand.dst  = (cnt == `DAT_PAGE_BYTES) ? pbuf[`DAT_BYTE_DST][2:0] : 3'h0;
        cand.addr = {pbuf[6], pbuf[7], pbuf[8], pbuf[9], pbuf[10], pbuf[11], pbuf[12], last_byte};
        page_ok = !overrun && cnt == `DAT_PAGE_BYTES
            && pbuf[0] == `DAT_PAGE_CODE && pbuf[1] == 8'h00
            && {pbuf[2], pbuf[3]} == `DAT_PAGE_LEN
            && pair_ok(cand.src, cand.dst);
        case (state)
            dat_pkg::DAT_IDLE, dat_pkg::DAT_LOAD: begin
                if (PARAM_VALID_I) begin
                    next_state = dat_pkg::DAT_LOAD;
                    if (cnt == `DAT_PAGE_BYTES || overrun)
                        next_overrun = 1'b1;
                    else
                        next_pbuf[cnt] = PARAM_DATA_I;
                    if (cnt != `DAT_PAGE_BYTES)
                        next_cnt = cnt + 4'h1;
                    if (PARAM_LAST_I) begin
                        next_state    = dat_pkg::DAT_IDLE;
                        next_cnt      = 4'h0;
                        next_overrun  = 1'b0;
                        next_st_valid = 1'b1;
                        if (page_ok) begin
                            next_status = '{1'b1, `DAT_SK_NONE, `DAT_ASC_NONE};
                            next_req    = cand;
                            next_stored = 1'b1;
                        end else begin
                            next_status = '{1'b0, `DAT_SK_ILLEGAL, `DAT_ASC_BAD_PARAM};
                            next_stored = 1'b0;
                        end
                    end
                end else if (state == dat_pkg::DAT_IDLE && RECV_REQ_I) begin
                    if (stored) begin
                        next_res_addr = translate(req);
                        next_stored   = 1'b0;
                        next_state    = dat_pkg::DAT_SEND;
                    end else begin
                        next_st_valid = 1'b1;
                        next_status   = '{1'b0, `DAT_SK_ILLEGAL, `DAT_ASC_BAD_PARAM};
                    end
                end
            end
            dat_pkg::DAT_SEND: begin
                next_res_valid = 1'b1;
                next_res_last  = cnt == `DAT_PAGE_BYTES;
                if (cnt == 4'h0)
                    next_res_data = `DAT_PAGE_CODE;
                else if (cnt == 4'h1 || cnt == 4'h2)
                    next_res_data = 8'h00;
                else if (cnt == 4'h3)
                    next_res_data = 8'(`DAT_PAGE_LEN);
                else if (cnt == `DAT_BYTE_SRC)
                    next_res_data = {5'h0, req.dst};
                else if (cnt == `DAT_BYTE_DST)
                    next_res_data = {5'h0, req.src};
                else
                    next_res_data = res_addr[8 * (13 - cnt) +: 8];
                if (cnt == `DAT_PAGE_BYTES) begin
                    next_cnt   = 4'h0;
                    next_state = dat_pkg::DAT_IDLE;
                end else begin
                    next_cnt = cnt + 4'h1;
                end
            end
            default: next_state = dat_pkg::DAT_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state     <= dat_pkg::DAT_IDLE;
            cnt       <= 4'h0;
            overrun   <= 1'b0;
            req       <= '0;
            stored    <= 1'b0;
            res_addr  <= 64'h0;
            status    <= '{1'b0, `DAT_SK_NONE, `DAT_ASC_NONE};
            st_valid  <= 1'b0;
            res_valid <= 1'b0;
            res_data  <= 8'h00;
            res_last  <= 1'b0;
            for (int i = 0; i < 14; i++)
                pbuf[i] <= 8'h00;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            overrun   <= next_overrun;
            req       <= next_req;
            stored    <= next_stored;
            res_addr  <= next_res_addr;
            status    <= next_status;
            st_valid  <= next_st_valid;
            res_valid <= next_res_valid;
            res_data  <= next_res_data;
            res_last  <= next_res_last;
            for (int i = 0; i < 14; i++)
                pbuf[i] <= next_pbuf[i];
        end
    end

    assign STATUS_VALID_O = st_valid;
    assign STATUS_GOOD_O  = status.good;
    assign SENSE_KEY_O    = status.sense_key;
    assign ASC_O          = status.asc;
    assign RESULT_VALID_O = res_valid;
    assign RESULT_DATA_O  = res_data;
    assign RESULT_LAST_O  = res_last;

    property p_good_sense;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        STATUS_VALID_O && STATUS_GOOD_O |-> SENSE_KEY_O == `DAT_SK_NONE && ASC_O == `DAT_ASC_NONE;
    endproperty
    a_good_sense: assert property (p_good_sense) else $error("good status with sense");

    property p_check_sense;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        STATUS_VALID_O && !STATUS_GOOD_O |-> SENSE_KEY_O == `DAT_SK_ILLEGAL && ASC_O == `DAT_ASC_BAD_PARAM;
    endproperty
    a_check_sense: assert property (p_check_sense) else $error("check status sense wrong");

    property p_status_after_last;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        PARAM_VALID_I && PARAM_LAST_I && state != dat_pkg::DAT_SEND |=> STATUS_VALID_O;
    endproperty
    a_status_after_last: assert property (p_status_after_last) else $error("no status after list");

    property p_bad_header;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        PARAM_VALID_I && PARAM_LAST_I && state != dat_pkg::DAT_SEND && pbuf[0] != `DAT_PAGE_CODE
            |=> STATUS_VALID_O && !STATUS_GOOD_O;
    endproperty
    a_bad_header: assert property (p_bad_header) else $error("bad page code accepted");

    property p_pair_legal;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        stored |-> (fmt_block(req.src) && (req.dst == `DAT_FMT_BFI || req.dst == `DAT_FMT_PHYS))
            || (!fmt_block(req.src) && fmt_known(req.src) && req.dst == `DAT_FMT_LONG);
    endproperty
    a_pair_legal: assert property (p_pair_legal) else $error("illegal format pair stored");

    property p_src_known;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        stored |-> fmt_known(req.src) && req.src != req.dst;
    endproperty
    a_src_known: assert property (p_src_known) else $error("unknown source format stored");

    property p_page_length;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        state == dat_pkg::DAT_IDLE && RECV_REQ_I && !PARAM_VALID_I && stored
            |=> ##1 RESULT_VALID_O[*8] ##0 !RESULT_LAST_O ##6 RESULT_LAST_O;
    endproperty
    a_page_length: assert property (p_page_length) else $error("returned page not 14 bytes");

    property p_first_byte;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        RESULT_VALID_O && !$past(RESULT_VALID_O) |-> RESULT_DATA_O == `DAT_PAGE_CODE;
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("returned page code wrong");

    property p_consumed;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        $rose(state == dat_pkg::DAT_SEND) |-> !stored;
    endproperty
    a_consumed: assert property (p_consumed) else $error("request kept after receive");

endmodule : dat_top

// File: shared/dat_defs.svh
`ifndef DAT_DEFS_SVH
`define DAT_DEFS_SVH

// Page header
`define DAT_PAGE_CODE     8'h40
`define DAT_PAGE_LEN      16'h000a
`define DAT_PAGE_BYTES    4'hd
`define DAT_ADDR_FIRST    4'h6
`define DAT_BYTE_SRC      4'h4
`define DAT_BYTE_DST      4'h5

// Format codes
`define DAT_FMT_SHORT     3'h0
`define DAT_FMT_LONG      3'h3
`define DAT_FMT_BFI       3'h4
`define DAT_FMT_PHYS      3'h5

// Status and sense
`define DAT_SK_NONE       4'h0
`define DAT_SK_ILLEGAL    4'h5
`define DAT_ASC_NONE      8'h00
`define DAT_ASC_BAD_PARAM 8'h26

// Geometry, powers of two
`define DAT_SPT_LOG2      8
`define DAT_HEADS_LOG2    4
`define DAT_BPS_LOG2      9

`endif

// File: shared/dat_pkg.sv
package dat_pkg;

    typedef enum logic [2:0] {
        DAT_IDLE = 3'b001,
        DAT_LOAD = 3'b010,
        DAT_SEND = 3'b100
    } dat_state_e;

    typedef struct packed {
        logic       good;
        logic [3:0] sense_key;
        logic [7:0] asc;
    } dat_status_s;

    typedef struct packed {
        logic [2:0]  src;
        logic [2:0]  dst;
        logic [63:0] addr;
    } dat_req_s;

endpackage : dat_pkg

// File: verif/dat_host.sv
`timescale 1ns/1ps
module dat_host (
    // Clock
    input  wire logic       clk_i,
    // Parameter bytes toward the device
    output logic            param_valid_o,
    output logic [7:0]      param_data_o,
    output logic            param_last_o,
    // Receive command
    output logic            recv_req_o
);
    initial begin
        param_valid_o = 1'b0;
        param_data_o  = 8'h00;
        param_last_o  = 1'b0;
        recv_req_o    = 1'b0;
    end

    task automatic send(input logic [31:0] hdr, input logic [7:0] src, input logic [7:0] dst,
                        input logic [63:0] addr);
        logic [111:0] pg;
        pg = {hdr, src, dst, addr};
        for (int k = 0; k < 14; k++) begin
            @(negedge clk_i);
            param_valid_o = 1'b1;
            param_data_o  = pg[111-8*k -: 8];
            param_last_o  = (k == 13);
        end
        @(negedge clk_i);
        param_valid_o = 1'b0;
        param_last_o  = 1'b0;
        // Released data line must not keep showing the last byte
        param_data_o  = ~param_data_o;
    endtask : send

    // Sends the first n bytes of a page, zero bytes past byte 13
    task automatic send_count(input logic [111:0] pg, input int nbytes);
        for (int k = 0; k < nbytes; k++) begin
            @(negedge clk_i);
            param_valid_o = 1'b1;
            param_data_o  = (k < 14) ? pg[111-8*k -: 8] : 8'h00;
            param_last_o  = (k == nbytes - 1);
        end
        @(negedge clk_i);
        param_valid_o = 1'b0;
        param_last_o  = 1'b0;
        param_data_o  = ~param_data_o;
    endtask : send_count

    task automatic recv();
        @(negedge clk_i);
        recv_req_o = 1'b1;
        @(negedge clk_i);
        recv_req_o = 1'b0;
    endtask : recv
endmodule : dat_host

// File: verif/tb_top.sv
`timescale 1ns/1ps
`include "dat_defs.svh"
module tb_top;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       pv, pl, rq, sv, sg, rv, rl;
    logic [7:0] pd, asc, rd;
    logic [3:0] sk;
    int         failures = 0;
    int         n_compared = 0;
    localparam logic [31:0] HDR = {`DAT_PAGE_CODE, 8'h00, `DAT_PAGE_LEN};

    dat_top DUT (.CLOCK_I(clk), .RSTN_I(rst_n), .PARAM_VALID_I(pv), .PARAM_DATA_I(pd),
                 .PARAM_LAST_I(pl), .STATUS_VALID_O(sv), .STATUS_GOOD_O(sg), .SENSE_KEY_O(sk),
                 .ASC_O(asc), .RECV_REQ_I(rq), .RESULT_VALID_O(rv), .RESULT_DATA_O(rd),
                 .RESULT_LAST_O(rl));
    dat_host host (.clk_i(clk), .param_valid_o(pv), .param_data_o(pd), .param_last_o(pl),
                   .recv_req_o(rq));

    always #25 clk = ~clk;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Status already stands at the first negedge after the taking edge
    task automatic expect_status(input logic good);
        int i;
        for (i = 0; i < 20 && sv !== 1'b1; i++) @(negedge clk);
        check({i[3:0], sv, sg, sk, asc},
              {4'h0, 1'b1, good, good ? `DAT_SK_NONE : `DAT_SK_ILLEGAL,
               good ? `DAT_ASC_NONE : `DAT_ASC_BAD_PARAM});
    endtask : expect_status

    task automatic expect_page(input logic [2:0] dst, input logic [2:0] src, input logic [63:0] addr);
        logic [111:0] pg;
        int i;
        pg = {HDR, 5'h00, dst, 5'h00, src, addr};
        host.recv();
        for (i = 0; i < 20 && rv !== 1'b1; i++) @(negedge clk);
        check(i, 1);
        for (int n = 0; n < 14; n++) begin
            check({rv, rl, rd}, {1'b1, n == 13, pg[111-8*n -: 8]});
            @(negedge clk);
        end
        check(rv, 0);
    endtask : expect_page

    task automatic xlate(input logic [7:0] b4, input logic [2:0] dst, input logic [63:0] addr,
                         input logic [63:0] exp);
        host.send(HDR, b4, {5'h00, dst}, addr);
        expect_status(1'b1);
        expect_page(dst, b4[2:0], exp);
    endtask : xlate

    task automatic t_short_to_phys();
        // Junk in upper bits of the format byte, zeroed tail of a short address
        xlate({5'h1f, `DAT_FMT_SHORT}, `DAT_FMT_PHYS, {32'h00123456, 32'h0},
              {24'h000123, 8'h04, 32'h00000056});
    endtask : t_short_to_phys

    task automatic t_long_to_bfi();
        xlate({5'h0, `DAT_FMT_LONG}, `DAT_FMT_BFI, 64'h0000000abcdef012,
              {24'habcdef, 8'h00, 32'h00002400});
    endtask : t_long_to_bfi

    task automatic t_to_long();
        xlate({5'h0, `DAT_FMT_PHYS}, `DAT_FMT_LONG, {24'h000321, 8'h07, 32'h000000a5},
              64'h00000000003217a5);
        xlate({5'h0, `DAT_FMT_BFI}, `DAT_FMT_LONG, {24'h000010, 8'h02, 32'h00001e00},
              64'h000000000001020f);
    endtask : t_to_long

    task automatic t_illegal_pairs();
        logic [5:0] pairs [9] = '{6'o14, 6'o02, 6'o03, 6'o33, 6'o45, 6'o55, 6'o63, 6'o50, 6'o00};
        // A good request is stored first; a failed send must discard it
        host.send(HDR, 8'h00, 8'h04, 64'h1);
        expect_status(1'b1);
        foreach (pairs[k]) begin
            host.send(HDR, {5'h0, pairs[k][5:3]}, {5'h0, pairs[k][2:0]}, 64'h1);
            expect_status(1'b0);
        end
        host.recv();
        expect_status(1'b0);
    endtask : t_illegal_pairs

    task automatic t_bad_header();
        logic [31:0] hdrs [3] = '{32'h4100000a, 32'h4001000a, 32'h4000000b};
        foreach (hdrs[k]) begin
            host.send(hdrs[k], 8'h00, 8'h05, 64'h1);
            expect_status(1'b0);
        end
    endtask : t_bad_header

    task automatic t_bad_length();
        // One byte short and one byte over must both be refused
        host.send_count({HDR, 8'h00, 8'h05, 64'h1}, 13);
        expect_status(1'b0);
        host.send_count({HDR, 8'h00, 8'h05, 64'h1}, 15);
        expect_status(1'b0);
    endtask : t_bad_length

    task automatic t_second_receive();
        xlate(8'h00, `DAT_FMT_BFI, 64'h0, 64'h0);
        host.recv();
        expect_status(1'b0);
    endtask : t_second_receive

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (5) @(negedge clk);
        check({sv, rv, sg}, 3'b000);
        rst_n = 1'b1;
        t_short_to_phys();
        t_long_to_bfi();
        t_to_long();
        t_illegal_pairs();
        t_bad_header();
        t_bad_length();
        t_second_receive();
        report_and_stop();
    end

    initial begin
        #400000;
        failures++;
        report_and_stop();
    end
endmodule : tb_top
